// ---- inc/dcs_cfg.svh ----
// offsets, field positions, reset values and timing counts of the debug control block
`ifndef DCS_CFG_SVH
`define DCS_CFG_SVH
`define DCS_CLK_HZ          20000000
`define DCS_ADDR_CTRL       4'h0
`define DCS_ADDR_STAT       4'h4
`define DCS_CTRL_MODE_BIT   7
`define DCS_CTRL_BRK_BIT    6
`define DCS_CTRL_ACK_BIT    5
`define DCS_CTRL_RST_BIT    0
`define DCS_STAT_DBG_BIT    7
`define DCS_STAT_HALT_BIT   6
`define DCS_STAT_FRPN_BIT   5
`define DCS_CTRL_RESET      8'h00
`define DCS_STAT_RESET      8'h00
`define DCS_BRK_OPCODE      8'h00
`define DCS_ACK_BYTE        8'hFF
`define DCS_VAL_RST_STOP    8'h81
`define DCS_VAL_RST_GO      8'h41
`define DCS_VAL_RUN         8'h40
`define DCS_RST_LEN         4'h8
`endif

// ---- inc/dcs_pkg.sv ----
// types of the debug control block
package dcs_pkg;
  typedef enum logic [1:0] {
    DCS_IDLE,
    DCS_RESETTING
  } dcs_rst_state_t;

  typedef struct packed {
    logic       mode;
    logic       breakpoint_opcode;
    logic       ack_en;
    logic       rst_req;
  } dcs_ctrl_t;

  typedef struct packed {
    dcs_ctrl_t      ctrl;
    dcs_rst_state_t rst_st;
    logic [3:0]     rst_cnt;
    logic           ack;
    logic [7:0]     rdata;
    logic           ack_vld;
    logic [7:0]     ack_data;
  } dcs_state_t;

  typedef struct packed {
    logic       cyc;
    logic       stb;
    logic       we;
    logic [3:0] adr;
    logic [3:0] sel;
    logic [7:0] dat;
  } dcs_wb_req_t;
endpackage

// ---- design/dcs_status.sv ----
// status register assembly for the debug control block
`timescale 1ns/1ps
`include "dcs_cfg.svh"
module dcs_status
  import dcs_pkg::*;
(
  input  wire logic       debug_mode_i,          // current debug mode
  input  wire logic       halt_i,                // core in halt mode
  input  wire logic       flash_read_protect_i,  // read-protect option set
  output logic [7:0]      status_o               // assembled status byte
);
  // reserved low bits read as zero
  always_comb
  begin
    status_o = `DCS_STAT_RESET;
    status_o[`DCS_STAT_DBG_BIT]  = debug_mode_i;
    status_o[`DCS_STAT_HALT_BIT] = halt_i;
    status_o[`DCS_STAT_FRPN_BIT] = ~flash_read_protect_i;
  end
endmodule // dcs_status

// ---- design/dcs_top.sv ----
// debug control and status registers behind a classic wishbone slave
`timescale 1ns/1ps
`include "dcs_cfg.svh"
module dcs_top
  import dcs_pkg::*;
(
  input  wire logic        clk_i,                 // system clock, 20 mhz
  input  wire logic        rst_i,                 // synchronous reset, active high
  input  wire logic        wb_cyc_i,              // wishbone cycle
  input  wire logic        wb_stb_i,              // wishbone strobe
  input  wire logic        wb_we_i,               // wishbone write
  input  wire logic [3:0]  wb_adr_i,              // byte address
  input  wire logic [3:0]  wb_sel_i,              // byte selects
  input  wire logic [31:0] wb_dat_i,              // write data
  output logic [31:0]      wb_dat_o,              // read data
  output logic             wb_ack_o,              // acknowledge
  output logic             wb_err_o,              // never raised; unmapped addresses read the status byte
  input  wire logic [7:0]  opcode_i,              // opcode being decoded
  input  wire logic        opcode_vld_i,          // decode strobe
  input  wire logic        halt_i,                // core in halt mode
  input  wire logic        flash_read_protect_i,  // read-protect option
  output logic             fetch_stop_o,          // stop instruction fetch
  output logic             brk_nop_o,             // treat breakpoint as nop
  output logic             por_req_o,             // request por, keep debugger
  output logic             ack_vld_o,             // acknowledge byte valid
  output logic [7:0]       ack_byte_o             // acknowledge byte to host
);
  ////////////////////////////////////////////////////////////////////////
  dcs_state_t  s_q;         // all state
  dcs_state_t  s_d;         // next state
  dcs_wb_req_t req;         // bundled bus request
  logic [7:0]  status;      // status byte
  logic        req_new;     // fresh bus request
  logic        wr_ctrl;     // write to control byte lane
  logic        brk_hit;     // armed breakpoint decoded
  logic        rst_done;    // internal reset sequence finished

  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i,
                 sel: wb_sel_i, dat: wb_dat_i[7:0]};

  dcs_status u_status (
    .debug_mode_i         (s_q.ctrl.mode),
    .halt_i               (halt_i),
    .flash_read_protect_i (flash_read_protect_i),
    .status_o             (status)
  );

  ////////////////////////////////////////////////////////////////////////
  // decode: ack drops the cycle after it was given, so one access per two
  always_comb
  begin
    req_new  = req.cyc && req.stb && !s_q.ack;
    wr_ctrl  = req_new && req.we && req.sel[0] && (req.adr == `DCS_ADDR_CTRL);
    brk_hit  = opcode_vld_i && (opcode_i == `DCS_BRK_OPCODE) && s_q.ctrl.breakpoint_opcode;
    rst_done = (s_q.rst_st == DCS_RESETTING) && (s_q.rst_cnt == 4'h0);
  end

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    s_d         = s_q;
    s_d.ack     = req_new;
    s_d.ack_vld = 1'b0;
    // bus reads
    if (req_new && !req.we)
    begin
      if (req.adr == `DCS_ADDR_CTRL)
        s_d.rdata = {s_q.ctrl.mode, s_q.ctrl.breakpoint_opcode, s_q.ctrl.ack_en, 4'h0,
                     s_q.ctrl.rst_req};
      else
        s_d.rdata = status;
    end
    // control writes; 81h/41h/40h fall out of the field layout
    if (wr_ctrl)
    begin
      s_d.ctrl.mode   = req.dat[`DCS_CTRL_MODE_BIT];
      s_d.ctrl.breakpoint_opcode    = req.dat[`DCS_CTRL_BRK_BIT];
      s_d.ctrl.ack_en = req.dat[`DCS_CTRL_ACK_BIT];
      // protected part: debug mode cannot be written to 0
      if (flash_read_protect_i && s_q.ctrl.mode)
        s_d.ctrl.mode = 1'b1;
      if (req.dat[`DCS_CTRL_RST_BIT] && (s_q.rst_st == DCS_IDLE))
      begin
        s_d.ctrl.rst_req = 1'b1;
        s_d.rst_st       = DCS_RESETTING;
        s_d.rst_cnt      = `DCS_RST_LEN;
      end
    end
    // breakpoint wins over a concurrent write clearing debug mode
    if (brk_hit)
    begin
      s_d.ctrl.mode = 1'b1;
      if (s_q.ctrl.ack_en)
      begin
        s_d.ack_vld  = 1'b1;
        s_d.ack_data = `DCS_ACK_BYTE;
      end
    end
    // reset sequence countdown
    unique case (s_q.rst_st)
      DCS_IDLE:
        ;
      DCS_RESETTING:
      begin
        if (rst_done)
        begin
          s_d.ctrl.rst_req = 1'b0;
          s_d.rst_st       = DCS_IDLE;
        end
        else
          s_d.rst_cnt = s_q.rst_cnt - 4'h1;
      end
      default:
        s_d.rst_st = DCS_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // state register; breakpoint arm clears on reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_q          <= '0;
      s_q.ctrl     <= dcs_ctrl_t'(4'(`DCS_CTRL_RESET));   // control bits all clear
      s_q.rst_st   <= DCS_IDLE;
    end
    else
      s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign wb_ack_o     = s_q.ack;
  assign wb_err_o     = 1'b0;
  assign wb_dat_o     = {24'h00_0000, s_q.rdata};
  assign fetch_stop_o = s_q.ctrl.mode;
  assign brk_nop_o    = !s_q.ctrl.breakpoint_opcode;
  assign por_req_o    = s_q.ctrl.rst_req;
  assign ack_vld_o    = s_q.ack_vld;
  assign ack_byte_o   = s_q.ack_data;

  ////////////////////////////////////////////////////////////////////////
  // checks; properties look at registered outputs one edge after their cause
  // a taken bus request, answered by a one-cycle acknowledge
  sequence s_wb_take;
    req_new;
  endsequence
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  // a read of the status byte
  sequence s_stat_read;
    req_new && !req.we && (req.adr == `DCS_ADDR_STAT);
  endsequence
  // a control write that starts the internal reset sequence
  sequence s_rst_start;
    wr_ctrl && req.dat[`DCS_CTRL_RST_BIT] && (s_q.rst_st == DCS_IDLE);
  endsequence

  // every access is acked once; a stuck ack would let one request count twice
  AST_BUSACK: assert property (@(posedge clk_i) disable iff (rst_i)
    s_wb_take |=> s_ack_pulse)
    else $error("bus acknowledge not a single pulse");
  // writing the mode bit set always enters debug mode
  AST_FETCH: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_ctrl && req.dat[`DCS_CTRL_MODE_BIT] |=> fetch_stop_o)
    else $error("debug mode write did not stop fetch");
  // with read-protect in force only a reset may leave debug mode
  AST_PROTECT: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_ctrl && flash_read_protect_i && s_q.ctrl.mode |=> fetch_stop_o)
    else $error("protected debug mode was left");
  // an unprotected write of mode zero lets the core fetch again
  AST_RESUME: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_ctrl && !req.dat[`DCS_CTRL_MODE_BIT] && !flash_read_protect_i && !brk_hit
    |=> !fetch_stop_o)
    else $error("fetch did not resume");
  // an armed breakpoint opcode always stops the core
  AST_BRK: assert property (@(posedge clk_i) disable iff (rst_i)
    brk_hit |=> fetch_stop_o)
    else $error("breakpoint missed");
  // a disarmed breakpoint must not stop the core
  AST_NOP: assert property (@(posedge clk_i) disable iff (rst_i)
    opcode_vld_i && !s_q.ctrl.breakpoint_opcode && !s_q.ctrl.mode && !wr_ctrl |=> !fetch_stop_o)
    else $error("disarmed breakpoint stopped");
  // status reads: the byte is built from the values seen at the taking edge
  AST_DBG: assert property (@(posedge clk_i) disable iff (rst_i)
    s_stat_read |=> wb_dat_o[`DCS_STAT_DBG_BIT] == $past(s_q.ctrl.mode))
    else $error("debug flag wrong");
  AST_HALT: assert property (@(posedge clk_i) disable iff (rst_i)
    s_stat_read |=> wb_dat_o[`DCS_STAT_HALT_BIT] == $past(halt_i))
    else $error("halt flag wrong");
  // the protect flag reads inverted: low means the option is in force
  AST_FRP: assert property (@(posedge clk_i) disable iff (rst_i)
    s_stat_read |=> wb_dat_o[`DCS_STAT_FRPN_BIT] != $past(flash_read_protect_i))
    else $error("protect flag wrong");
  // reset-and-stop enters debug mode and raises the reset request
  AST_RSTSTOP: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_ctrl && (req.dat == `DCS_VAL_RST_STOP) && (s_q.rst_st == DCS_IDLE)
    |=> fetch_stop_o && por_req_o)
    else $error("reset-stop failed");
  // reset-and-go leaves debug mode and raises the reset request
  AST_RSTGO: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_ctrl && (req.dat == `DCS_VAL_RST_GO) && (s_q.rst_st == DCS_IDLE)
    && !flash_read_protect_i && !brk_hit |=> !fetch_stop_o && por_req_o)
    else $error("reset-go failed");
  // run from debug mode resumes fetch and keeps the breakpoint armed
  AST_RUN: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_ctrl && (req.dat == `DCS_VAL_RUN) && s_q.ctrl.mode && !flash_read_protect_i
    && !brk_hit |=> !fetch_stop_o && !brk_nop_o)
    else $error("run failed");
  // acknowledge byte only when enabled
  AST_ACK: assert property (@(posedge clk_i) disable iff (rst_i)
    brk_hit && s_q.ctrl.ack_en |=> ack_vld_o && (ack_byte_o == `DCS_ACK_BYTE))
    else $error("ack byte missing");
  AST_NOACK: assert property (@(posedge clk_i) disable iff (rst_i)
    brk_hit && !s_q.ctrl.ack_en |=> !ack_vld_o)
    else $error("ack byte sent while disabled");
  // request stands for the whole countdown, then clears by itself
  AST_RSTCLR: assert property (@(posedge clk_i) disable iff (rst_i)
    s_rst_start |=> por_req_o [*8] ##2 !por_req_o)
    else $error("reset request stuck");
endmodule // dcs_top

// ---- test/dcs_host_model.sv ----
// debug host model that collects acknowledge bytes sent by the block
`timescale 1ns/1ps
module dcs_host_model (
  input  wire logic       clk_i,       // system clock
  input  wire logic       rst_i,       // sync reset, active high
  input  wire logic       ack_vld_i,   // acknowledge byte valid
  input  wire logic [7:0] ack_byte_i,  // acknowledge byte
  output int              n_ack_o,     // bytes taken so far
  output logic [7:0]      byte_o       // last byte taken
);
  // one byte taken per valid pulse; a stuck valid shows up as extra bytes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      n_ack_o <= 0;
      byte_o  <= 8'h00;
    end
    else if (ack_vld_i)
    begin
      n_ack_o <= n_ack_o + 1;
      byte_o  <= ack_byte_i;
    end
  end
endmodule // dcs_host_model

// ---- test/tb.sv ----
// testbench for the debug control and status registers
`timescale 1ns/1ps
`include "dcs_cfg.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb;
  import dcs_pkg::*;
  logic        clk_i, rst_i, wb_ack_o, wb_err_o, op_vld, halt, flash_read_protect;
  logic        fetch_stop, brk_nop, por_req, ack_vld;
  logic [31:0] wb_dat_o;
  logic [7:0]  opcode, ack_byte, rd, host_byte;
  dcs_wb_req_t req;                            // wishbone request bundle
  int          host_n, n_mismatch, checks_done;
  dcs_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb),
    .wb_we_i(req.we), .wb_adr_i(req.adr), .wb_sel_i(req.sel), .wb_dat_i({24'h0, req.dat}),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .opcode_i(opcode),
    .opcode_vld_i(op_vld), .halt_i(halt), .flash_read_protect_i(flash_read_protect),
    .fetch_stop_o(fetch_stop), .brk_nop_o(brk_nop), .por_req_o(por_req),
    .ack_vld_o(ack_vld), .ack_byte_o(ack_byte));
  dcs_host_model i_host (.clk_i(clk_i), .rst_i(rst_i), .ack_vld_i(ack_vld),
    .ack_byte_i(ack_byte), .n_ack_o(host_n), .byte_o(host_byte));
  // clock at 20 mhz
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // classic single cycle; ack sampled at the edge, so values read here are pre-edge
  task automatic bus(input logic we, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'h1, dat: d};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o[7:0];
    req <= '0;
    // an answer that never comes ends the run here
    if (wb_ack_o !== 1'b1)
    begin
      n_mismatch++;
      $display("CHECK FAILED wb_ack exp 1 got %b", wb_ack_o);
      final_report;
    end
    else
      @(posedge clk_i);
  endtask
  task automatic rd_chk(input string nm, input logic [3:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    `CHK(nm, e, rd)
  endtask
  // one decode strobe of the breakpoint opcode
  task automatic brk_op;
    opcode <= `DCS_BRK_OPCODE;
    op_vld <= 1'b1;
    @(posedge clk_i);
    op_vld <= 1'b0;
    @(posedge clk_i);
  endtask
  // bounded wait for the reset request to finish; it stands len+1 cycles, is
  // watched from two edges after the take and seen gone one edge late: len edges
  task automatic wait_por;
    int n;
    n = 0;
    while (por_req !== 1'b0 && n < 40)
    begin
      @(posedge clk_i);
      n++;
    end
    `CHK("por_done", 1'b1, n < 40)
    `CHK("por_len", `DCS_RST_LEN, n)
    if (por_req !== 1'b0)
      final_report;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    rst_i = 1'b1;
    req = '0;
    opcode = 8'h00;
    op_vld = 1'b0;
    halt = 1'b0;
    flash_read_protect = 1'b0;
    n_mismatch = 0;
    checks_done = 0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK("brk_nop", 1'b1, brk_nop)
    rd_chk("ctrl_rst", `DCS_ADDR_CTRL, 8'h00);
    rd_chk("stat_rst", `DCS_ADDR_STAT, 8'h20);
    brk_op;
    `CHK("stop_disarmed", 1'b0, fetch_stop)
    bus(1'b1, `DCS_ADDR_CTRL, 8'h80);
    `CHK("stop_mode", 1'b1, fetch_stop)
    bus(1'b1, `DCS_ADDR_STAT, 8'h00); // host keeps reserved bits zero
    `CHK("wb_err", 1'b0, wb_err_o)
    rd_chk("stat_dbg", `DCS_ADDR_STAT, 8'hA0);
    bus(1'b1, `DCS_ADDR_CTRL, 8'h00);
    `CHK("stop_clear", 1'b0, fetch_stop)
    bus(1'b1, `DCS_ADDR_CTRL, 8'h60);
    `CHK("brk_armed", 1'b0, brk_nop)
    brk_op;
    `CHK("stop_brk", 1'b1, fetch_stop)
    bus(1'b1, `DCS_ADDR_CTRL, `DCS_VAL_RUN);
    `CHK("run", 1'b0, fetch_stop)
    `CHK("ack_count", 1, host_n)
    `CHK("ack_byte", `DCS_ACK_BYTE, host_byte)
    bus(1'b1, `DCS_ADDR_CTRL, `DCS_VAL_RST_STOP);
    `CHK("por_req", 1'b1, por_req)
    wait_por;
    `CHK("rst_stop", 1'b1, fetch_stop)
    rd_chk("rst_clr", `DCS_ADDR_CTRL, 8'h80);
    bus(1'b1, `DCS_ADDR_CTRL, `DCS_VAL_RST_GO);
    wait_por;
    `CHK("rst_go", 1'b0, fetch_stop)
    halt <= 1'b1;
    flash_read_protect <= 1'b1;
    rd_chk("stat_halt", `DCS_ADDR_STAT, 8'h40);
    // breakpoint armed again by reset-and-go, acknowledge now disabled
    brk_op;
    `CHK("stop_brk_noack", 1'b1, fetch_stop)
    // read-protect in force: a zero write may not leave debug mode
    bus(1'b1, `DCS_ADDR_CTRL, 8'h00);
    `CHK("stop_protect", 1'b1, fetch_stop)
    `CHK("ack_count_off", 1, host_n)
    // only a reset leaves protected debug mode
    rst_i <= 1'b1;
    halt <= 1'b0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK("stop_rst2", 1'b0, fetch_stop)
    `CHK("brk_nop_rst2", 1'b1, brk_nop)
    rd_chk("ctrl_rst2", `DCS_ADDR_CTRL, 8'h00);
    rd_chk("stat_rst2", `DCS_ADDR_STAT, 8'h00);
    final_report;
  end
endmodule // tb
